// ===== dgc_engine.sv
// Register file, correction pipeline and output select of the twenty level DACs
// Operation
// - Corrected word is (gain+1)/2^16 times input plus offset minus 2^15.
// - Every gain register resets to 0xffff, unity gain.
// - Every offset register resets to 0x8000, zero offset.
// - Input word registers are sixteen bits, holding the host's raw code.
// - Only input word writes start a calculation; gain or offset writes do not.
// - Each result is stored in its cached register before any mode change.
// - A result for the active set reaches the DAC one cycle after it is cached, unless busy or held.
// - Force DAC has six sets: voltage, four internal ranges, one external.
// - Force DAC keeps six cached corrected words, one per set.
// - Each comparator DAC has six sets and six cached words likewise.
// - Each clamp DAC has two sets: voltage and one for all currents.
// - The arrangement is replicated for twenty DACs, five per channel.
// - Force DAC keeps sixteen input bits even at quarter-scale gain.
// - Busy is low during input write and calculation; no output updates then.
// - Cached words of inactive sets reach no DAC until a mode command selects them.
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "dgc_regs.svh"

module dgc_engine
   import dgc_pkg::*;
(
   input  wire logic                     core_clk,
   input  wire logic                     srst,
   input  wire logic [`DGC_ADDR_W-1:0]   addr,
   input  wire logic [`DGC_DATA_W-1:0]   wdata,
   input  wire logic                     wr_en,
   input  wire logic                     rd_en,
   output logic [`DGC_DATA_W-1:0]        rdata,
   output logic                          busy_n,
   output logic [15:0]                   dac_code [0:`DGC_DAC_NUM-1]
);

   // Set count of a DAC kind
   function automatic logic [2:0] set_count(input logic [2:0] kind);
      logic [2:0] n;
      n = 3'h0;
      case (kind)
         DGC_KIND_FORCE,
         DGC_KIND_CMP_HI,
         DGC_KIND_CMP_LO:   n = 3'(`DGC_SET_MAX);
         DGC_KIND_CLAMP_HI,
         DGC_KIND_CLAMP_LO: n = 3'(`DGC_SET_CLAMP);
         default:           n = 3'h0;
      endcase
      return n;
   endfunction

   // Set selected by a channel mode for a DAC kind
   function automatic logic [2:0] active_set(input logic [2:0] kind,
                                             input logic [2:0] mode);
      logic [2:0] s;
      s = mode;
      if (kind == DGC_KIND_CLAMP_HI || kind == DGC_KIND_CLAMP_LO) begin
         s = (mode == DGC_MODE_VOLT) ? 3'h0 : 3'h1;
      end
      return s;
   endfunction

   // Flat storage index of channel, kind and set
   function automatic logic [`DGC_SLOT_W-1:0] slot_of(input logic [1:0] ch,
                                                      input logic [2:0] kind,
                                                      input logic [2:0] set);
      logic [`DGC_SLOT_W-1:0] idx;
      idx = 7'(ch) * 7'd30 + 7'(kind) * 7'd6 + 7'(set);
      return idx;
   endfunction

   // Level register storage
   logic [15:0]             input_word_reg     [0:`DGC_SLOT_NUM-1];
   logic [15:0]             gain_factor_reg    [0:`DGC_SLOT_NUM-1];
   logic [15:0]             offset_trim_reg    [0:`DGC_SLOT_NUM-1];
   logic [15:0]             corrected_word_reg [0:`DGC_SLOT_NUM-1];
   logic [2:0]              mode_reg           [0:`DGC_CH_NUM-1];
   logic                    hold_reg;
   logic [`DGC_DATA_W-1:0]  rdata_reg;
   logic [`DGC_DAC_NUM-1:0] pend_reg;
   logic [15:0]             out_reg            [0:`DGC_DAC_NUM-1];

   // Address decode
   wire                     is_ctrl   = addr[`DGC_CTRL_BIT];
   wire  [1:0]              a_fld     = addr[`DGC_FLD_LSB +: 2];
   wire  [1:0]              a_ch      = addr[`DGC_CH_LSB +: 2];
   wire  [2:0]              a_kind    = addr[`DGC_KIND_LSB +: 3];
   wire  [2:0]              a_set     = addr[`DGC_SET_LSB +: 3];
   wire                     lvl_ok    = !is_ctrl && (a_kind < 3'(`DGC_KIND_NUM))
                                        && (a_set < set_count(a_kind));
   wire  [`DGC_SLOT_W-1:0]  a_slot    = slot_of(a_ch, a_kind, a_set);
   wire                     wr_input  = wr_en && lvl_ok && (a_fld == `DGC_FLD_INPUT);
   wire                     wr_gain   = wr_en && lvl_ok && (a_fld == `DGC_FLD_GAIN);
   wire                     wr_offset = wr_en && lvl_ok && (a_fld == `DGC_FLD_OFFSET);
   wire                     mode_hit  = (addr[`DGC_ADDR_W-1:2] == `DGC_MODE_BASE >> 2);
   wire                     wr_mode   = wr_en && mode_hit
                                        && (wdata[2:0] <= `DGC_MODE_MAX);
   wire                     wr_hold   = wr_en && (addr == `DGC_HOLD_ADDR);
   wire                     out_hit   = (addr >= `DGC_OUT_BASE)
                                        && (addr < `DGC_OUT_BASE + 11'(`DGC_DAC_NUM));
   wire  [4:0]              out_idx   = 5'(addr - `DGC_OUT_BASE);

   // Correction pipeline
   wire                     calc_busy;
   wire                     calc_done;
   wire  [`DGC_SLOT_W-1:0]  calc_slot;
   wire  [15:0]             calc_word;

   dgc_calc u_calc (
      .core_clk       (core_clk),
      .srst           (srst),
      .start          (wr_input),
      .slot_in        (a_slot),
      .input_word     (wdata),
      .gain_factor    (gain_factor_reg[a_slot]),
      .offset_trim    (offset_trim_reg[a_slot]),
      .calc_busy      (calc_busy),
      .done           (calc_done),
      .slot_out       (calc_slot),
      .corrected_word (calc_word)
   );

   // Busy covers the write cycle and both pipeline stages
   wire                     busy      = wr_input | calc_busy;
   wire                     apply_ok  = !busy && !hold_reg;

   // Level registers
   always_ff @(posedge core_clk) begin
      if (srst) begin
         for (int i = 0; i < `DGC_SLOT_NUM; i++) begin
            input_word_reg[i]     <= 16'h0000;
            gain_factor_reg[i]    <= `DGC_GAIN_RST;
            offset_trim_reg[i]    <= `DGC_OFFS_RST;
            corrected_word_reg[i] <= 16'h0000;
         end
      end else begin
         if (wr_input) begin
            input_word_reg[a_slot] <= wdata;
         end
         if (wr_gain) begin
            gain_factor_reg[a_slot] <= wdata;
         end
         if (wr_offset) begin
            offset_trim_reg[a_slot] <= wdata;
         end
         if (calc_done) begin
            corrected_word_reg[calc_slot] <= calc_word;
         end
      end
   end

   // Control registers
   always_ff @(posedge core_clk) begin
      if (srst) begin
         for (int c = 0; c < `DGC_CH_NUM; c++) begin
            mode_reg[c] <= DGC_MODE_VOLT;
         end
         hold_reg <= 1'b0;
      end else begin
         if (wr_mode) begin
            mode_reg[addr[1:0]] <= wdata[2:0];
         end
         if (wr_hold) begin
            hold_reg <= wdata[0];
         end
      end
   end

   // Per-DAC output path, five DACs per channel
   genvar g;
   generate
      for (g = 0; g < `DGC_DAC_NUM; g++) begin : g_dac
         localparam logic [1:0] CH   = 2'(g / `DGC_KIND_NUM);
         localparam logic [2:0] KIND = 3'(g % `DGC_KIND_NUM);

         wire  [2:0]             act_set  = active_set(KIND, mode_reg[CH]);
         wire  [`DGC_SLOT_W-1:0] act_slot = slot_of(CH, KIND, act_set);
         wire                    mode_ev  = wr_mode && (addr[1:0] == CH);
         wire                    calc_ev  = calc_done && (calc_slot == act_slot);
         wire                    pend_set = mode_ev | calc_ev;
         wire                    apply    = pend_reg[g] && apply_ok;

         always_ff @(posedge core_clk) begin
            if (srst) begin
               pend_reg[g] <= 1'b0;
            end else begin
               pend_reg[g] <= (pend_reg[g] && !apply) || pend_set;
            end
         end

         always_ff @(posedge core_clk) begin
            if (srst) begin
               out_reg[g] <= 16'h0000;
            end else if (apply) begin
               out_reg[g] <= corrected_word_reg[act_slot];
            end
         end

         assign dac_code[g] = out_reg[g];
      end
   endgenerate

   // Read data mux
   logic [`DGC_DATA_W-1:0]  rd_mux;

   always_comb begin
      rd_mux = 16'h0000;
      if (lvl_ok) begin
         case (a_fld)
            `DGC_FLD_INPUT:  rd_mux = input_word_reg[a_slot];
            `DGC_FLD_GAIN:   rd_mux = gain_factor_reg[a_slot];
            `DGC_FLD_OFFSET: rd_mux = offset_trim_reg[a_slot];
            `DGC_FLD_CORR:   rd_mux = corrected_word_reg[a_slot];
            default:         rd_mux = 16'h0000;
         endcase
      end else if (mode_hit) begin
         rd_mux = {13'h0000, mode_reg[addr[1:0]]};
      end else if (addr == `DGC_HOLD_ADDR) begin
         rd_mux = {15'h0000, hold_reg};
      end else if (addr == `DGC_STAT_ADDR) begin
         rd_mux = {14'h0000, |pend_reg, busy};
      end else if (out_hit) begin
         rd_mux = out_reg[out_idx];
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdata_reg <= 16'h0000;
      end else if (rd_en) begin
         rdata_reg <= rd_mux;
      end else begin
         rdata_reg <= 16'h0000;
      end
   end

   assign rdata  = rdata_reg;
   assign busy_n = !busy;

endmodule // dgc_engine

// ===== dgc_regs.svh
// Register map, reset values and sizes of the DAC gain and offset correction engine
`ifndef DGC_REGS_SVH
`define DGC_REGS_SVH

`define DGC_ADDR_W      11
`define DGC_DATA_W      16
`define DGC_CH_NUM      4
`define DGC_KIND_NUM    5
`define DGC_DAC_NUM     20
`define DGC_SET_MAX     6
`define DGC_SET_CLAMP   2
`define DGC_SLOT_NUM    120
`define DGC_SLOT_W      7

// Address fields of the level area: {field, channel, kind, set}
`define DGC_CTRL_BIT    10
`define DGC_FLD_LSB     8
`define DGC_CH_LSB      6
`define DGC_KIND_LSB    3
`define DGC_SET_LSB     0
`define DGC_FLD_INPUT   2'h0
`define DGC_FLD_GAIN    2'h1
`define DGC_FLD_OFFSET  2'h2
`define DGC_FLD_CORR    2'h3

// Control area
`define DGC_MODE_BASE   11'h400
`define DGC_HOLD_ADDR   11'h404
`define DGC_STAT_ADDR   11'h405
`define DGC_OUT_BASE    11'h420

// Reset values and arithmetic constants
`define DGC_GAIN_RST    16'hffff
`define DGC_OFFS_RST    16'h8000
`define DGC_HALF_SCALE  19'h08000
`define DGC_CODE_MAX    19'h0ffff
`define DGC_MODE_MAX    3'h5

`endif

// ===== dgc_pkg.sv
// Types of the DAC gain and offset correction engine
package dgc_pkg;

   typedef enum logic [2:0] {
      DGC_KIND_FORCE    = 3'h0,
      DGC_KIND_CMP_HI   = 3'h1,
      DGC_KIND_CMP_LO   = 3'h2,
      DGC_KIND_CLAMP_HI = 3'h3,
      DGC_KIND_CLAMP_LO = 3'h4
   } dgc_kind_t;

   typedef enum logic [2:0] {
      DGC_MODE_VOLT  = 3'h0,
      DGC_MODE_I0    = 3'h1,
      DGC_MODE_I1    = 3'h2,
      DGC_MODE_I2    = 3'h3,
      DGC_MODE_I3    = 3'h4,
      DGC_MODE_IEXT  = 3'h5
   } dgc_mode_t;

endpackage

// ===== dgc_calc.sv
// Two-stage pipelined gain and offset correction arithmetic
`timescale 1ns/100ps
`include "dgc_regs.svh"

module dgc_calc
   import dgc_pkg::*;
(
   input  wire logic                     core_clk,
   input  wire logic                     srst,
   input  wire logic                     start,
   input  wire logic [`DGC_SLOT_W-1:0]   slot_in,
   input  wire logic [15:0]              input_word,
   input  wire logic [15:0]              gain_factor,
   input  wire logic [15:0]              offset_trim,
   output logic                          calc_busy,
   output logic                          done,
   output logic [`DGC_SLOT_W-1:0]        slot_out,
   output logic [15:0]                   corrected_word
);

   logic                    v0_reg;
   logic [`DGC_SLOT_W-1:0]  slot0_reg;
   logic [15:0]             x_reg;
   logic [15:0]             m_reg;
   logic [15:0]             c_reg;
   logic                    v1_reg;
   logic [`DGC_SLOT_W-1:0]  slot1_reg;
   logic [15:0]             res_reg;

   // Full 33-bit product keeps all input bits even at small gain
   wire  [16:0]             gain_p1 = {1'b0, m_reg} + 17'h00001;
   wire  [32:0]             product = gain_p1 * {17'h00000, x_reg};
   wire  [18:0]             sum     = {2'b00, product[32:16]} + {3'b000, c_reg}
                                      - `DGC_HALF_SCALE;
   wire                     neg     = sum[18];
   wire                     over    = !neg && (sum > `DGC_CODE_MAX);
   wire  [15:0]             sat     = neg ? 16'h0000 : over ? 16'hffff : sum[15:0];

   always_ff @(posedge core_clk) begin
      if (srst) begin
         v0_reg <= 1'b0;
         v1_reg <= 1'b0;
      end else begin
         v0_reg <= start;
         v1_reg <= v0_reg;
      end
   end

   always_ff @(posedge core_clk) begin
      slot0_reg <= slot_in;
      x_reg     <= input_word;
      m_reg     <= gain_factor;
      c_reg     <= offset_trim;
      slot1_reg <= slot0_reg;
      res_reg   <= sat;
   end

   assign calc_busy      = v0_reg | v1_reg;
   assign done           = v1_reg;
   assign slot_out       = slot1_reg;
   assign corrected_word = res_reg;

endmodule // dgc_calc

// ===== dgc_engine_monitor.sv
// Port checks of the correction engine
`timescale 1ns/100ps
`include "dgc_regs.svh"
module dgc_engine_monitor
   import dgc_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        srst,
   input wire logic [10:0] addr,
   input wire logic [15:0] wdata,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [15:0] rdata,
   input wire logic        busy_n,
   input wire logic [15:0] dac_code [0:`DGC_DAC_NUM-1]
);
   logic hold_reg;
   logic lvl_wr;
   assign lvl_wr = wr_en && addr[10:8] == 3'h0 && addr[5:3] < 3'h3 && addr[2:0] < 3'h6;
   // Shadow of the output hold bit
   always_ff @(posedge core_clk)
      if (srst) hold_reg <= 1'b0;
      else if (wr_en && addr == `DGC_HOLD_ADDR) hold_reg <= wdata[0];
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   busy_low_a: assert property (lvl_wr |-> !busy_n [*3])
      else $error("busy too short");
   busy_idle_a: assert property (busy_n && !wr_en ##1 !wr_en |-> busy_n)
      else $error("busy without write");
   gain_quiet_a: assert property (
      wr_en && addr[10:8] == 3'h1 && !$past(wr_en) && !$past(wr_en, 2) |-> busy_n)
      else $error("gain write started work");
   busy_freeze_a: assert property (!busy_n |=> $stable(dac_code[0]))
      else $error("output moved while busy");
   hold_freeze_a: assert property (hold_reg |=> $stable(dac_code[0]))
      else $error("output moved while held");
   status_busy_a: assert property (
      rd_en && addr == `DGC_STAT_ADDR |=> rdata[0] == !$past(busy_n))
      else $error("status busy wrong");
   first_out_a: assert property (
      rd_en && addr == `DGC_OUT_BASE |=> rdata == $past(dac_code[0]))
      else $error("readback of first output wrong");
   last_out_a: assert property (rd_en && addr == 11'h433 |=> rdata == $past(dac_code[19]))
      else $error("readback of last output wrong");
   force_set_a: assert property (
      rd_en && !addr[10] && addr[5:3] == 3'h0 && addr[2:0] > 3'h5 |=> rdata == 16'h0)
      else $error("force set beyond six mapped");
   clamp_set_a: assert property (
      rd_en && !addr[10] && addr[5:3] > 3'h2 && addr[2:0] > 3'h1 |=> rdata == 16'h0)
      else $error("clamp set beyond two mapped");
endmodule // dgc_engine_monitor

// ===== dgc_host.sv
// Host model driving the register port
`timescale 1ns/100ps
module dgc_host (
   input  wire logic        core_clk,
   input  wire logic [15:0] rdata,
   output logic      [10:0] addr,
   output logic      [15:0] wdata,
   output logic             wr_en,
   output logic             rd_en
);
   initial begin
      addr = 11'h0;
      wdata = 16'h0;
      wr_en = 1'b0;
      rd_en = 1'b0;
   end
   task automatic wr(input logic [10:0] a, input logic [15:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge core_clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [10:0] a, output logic [15:0] d);
      @(posedge core_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1;
      d = rdata;
   endtask
endmodule // dgc_host

// ===== dgc_engine_tb_top.sv
// Self-checking bench of the correction engine
`timescale 1ns/100ps
`include "dgc_regs.svh"
module dgc_engine_tb_top;
   import dgc_pkg::*;
   logic        core_clk, srst, wr_en, rd_en, busy_n;
   logic [10:0] addr;
   logic [15:0] wdata, rdata, d, e;
   logic [15:0] dac_code [0:`DGC_DAC_NUM-1];
   int          fail_count, total_checks, seed, r;
   initial core_clk = 1'b0;
   always #4 core_clk = ~core_clk;
   dgc_engine dgc_engine_i (.core_clk(core_clk), .srst(srst), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .busy_n(busy_n), .dac_code(dac_code));
   dgc_host dgc_host_i (.core_clk(core_clk), .rdata(rdata), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en));
   function automatic logic [10:0] la(input logic [1:0] f, input logic [1:0] ch,
      input logic [2:0] k, input logic [2:0] s);
      return {1'b0, f, ch, k, s};
   endfunction
   function automatic logic [15:0] calc(input logic [15:0] m, c, x);
      longint v;
      v = (((longint'(m) + 1) * x) >>> 16) + c - 32768;
      if (v < 0) return 16'h0;
      if (v > 65535) return 16'hffff;
      return v[15:0];
   endfunction
   task automatic chk(input string n, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic test_done;
      if (fail_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic idle;
      int n;
      n = 0;
      #1;
      while (busy_n !== 1'b1 && n < 20) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= 20) chk("busy_n", 16'h1, 16'h0);
   endtask
   // Load one register set and check its cached result, and its live result when live is set
   task automatic run(input logic [1:0] ch, input logic [2:0] k, s,
      input logic [15:0] m, c, x, input bit live);
      logic [15:0] v;
      dgc_host_i.wr(la(2'h1, ch, k, s), m);
      dgc_host_i.wr(la(2'h2, ch, k, s), c);
      dgc_host_i.wr(la(2'h0, ch, k, s), x);
      idle();
      dgc_host_i.rd(la(2'h3, ch, k, s), v);
      chk("cached", calc(m, c, x), v);
      if (live) chk("dac_code", calc(m, c, x), dac_code[ch * 5 + k]);
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      test_done();
   end
   initial begin
      seed = 32'h1c4ee19f;
      srst = 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      dgc_host_i.rd(la(2'h1, 2'h0, 3'h0, 3'h0), d);
      chk("gain", 16'hffff, d);
      dgc_host_i.rd(la(2'h2, 2'h0, 3'h0, 3'h0), d);
      chk("offset", 16'h8000, d);
      run(2'h0, 3'h0, 3'h0, 16'hffff, 16'h8000, 16'h1234, 1'b1);
      run(2'h1, 3'h0, 3'h0, 16'h4000, 16'h8000, 16'hfffd, 1'b1);
      run(2'h2, 3'h2, 3'h0, 16'hffff, 16'hffff, 16'hffff, 1'b1);
      run(2'h3, 3'h4, 3'h0, 16'hffff, 16'h8000, 16'h4321, 1'b1);
      run(2'h3, 3'h4, 3'h0, 16'h0, 16'h0, 16'h0, 1'b1);
      for (int i = 0; i < 16; i++) begin
         r = $random(seed);
         run(r[1:0], 3'(r[7:0] % 5), 3'h0, 16'($random(seed)), 16'($random(seed)),
            16'($random(seed)), 1'b1);
      end
      #1;
      e = dac_code[0];
      dgc_host_i.wr(la(2'h1, 2'h0, 3'h0, 3'h0), 16'h1000);
      repeat (4) @(posedge core_clk);
      #1;
      chk("no_recalc", e, dac_code[0]);
      // Preload every force set and both clamp-high sets of channel 3
      for (int s = 0; s < 6; s++) begin
         run(2'h3, 3'h0, 3'(s), 16'h7fff, 16'h8000, 16'(16'h0800 * (s + 1)), s == 0);
         if (s < 2) begin
            run(2'h3, 3'h3, 3'(s), 16'h7fff, 16'h8000, 16'(16'h0900 * (s + 1)), s == 0);
         end
      end
      for (int md = 0; md < 6; md++) begin
         dgc_host_i.wr(`DGC_MODE_BASE + 11'h3, 16'(md));
         repeat (2) @(posedge core_clk);
         #1;
         e = calc(16'h7fff, 16'h8000, 16'(16'h0800 * (md + 1)));
         chk("force", e, dac_code[15]);
         e = calc(16'h7fff, 16'h8000, md == 0 ? 16'h0900 : 16'h1200);
         chk("clamp", e, dac_code[18]);
      end
      for (int k = 0; k < 3; k++) begin
         run(2'h0, 3'(k), 3'h1, 16'h8000, 16'h9000, 16'h2000, 1'b0);
      end
      dgc_host_i.wr(`DGC_MODE_BASE, 16'h1);
      repeat (2) @(posedge core_clk);
      #1;
      chk("cmp_lo", calc(16'h8000, 16'h9000, 16'h2000), dac_code[2]);
      dgc_host_i.wr(`DGC_HOLD_ADDR, 16'h1);
      run(2'h3, 3'h0, 3'h5, 16'h7fff, 16'h8000, 16'h5555, 1'b0);
      chk("held", calc(16'h7fff, 16'h8000, 16'h3000), dac_code[15]);
      dgc_host_i.rd(`DGC_STAT_ADDR, d);
      chk("status_held", 16'h2, d);
      dgc_host_i.wr(`DGC_HOLD_ADDR, 16'h0);
      repeat (2) @(posedge core_clk);
      #1;
      chk("released", calc(16'h7fff, 16'h8000, 16'h5555), dac_code[15]);
      dgc_host_i.wr(la(2'h0, 2'h1, 3'h1, 3'h0), 16'h0100);
      dgc_host_i.rd(`DGC_STAT_ADDR, d);
      chk("status_busy", 16'h1, d);
      idle();
      dgc_host_i.rd(`DGC_OUT_BASE, d);
      dgc_host_i.rd(11'h433, d);
      dgc_host_i.rd(`DGC_STAT_ADDR, d);
      chk("status", 16'h0, d);
      dgc_host_i.rd(la(2'h1, 2'h0, 3'h0, 3'h6), d);
      chk("set6", 16'h0, d);
      dgc_host_i.rd(la(2'h1, 2'h0, 3'h4, 3'h2), d);
      chk("clamp_set2", 16'h0, d);
      // Mid-run reset restores defaults and clears outputs
      @(posedge core_clk);
      srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      #1;
      chk("reset_dac", 16'h0, dac_code[15]);
      dgc_host_i.rd(la(2'h1, 2'h0, 3'h0, 3'h0), d);
      chk("reset_gain", 16'hffff, d);
      dgc_host_i.rd(la(2'h2, 2'h2, 3'h2, 3'h0), d);
      chk("reset_offset", 16'h8000, d);
      test_done();
   end
endmodule // dgc_engine_tb_top
bind dgc_engine dgc_engine_monitor dgc_engine_monitor_i (.core_clk(core_clk), .srst(srst),
   .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .busy_n(busy_n),
   .dac_code(dac_code));
